//--- logic/select_defines.svh
// constants for the lower-memory and peripheral select block
`ifndef SELECT_DEFINES_SVH
`define SELECT_DEFINES_SVH
`define SEL_ADDR_W 20
`define SEL_LOWER_TOP 20'h80000
`define SEL_KB_SHIFT 10
`define SEL_PBASE_W 10
`define SEL_NUM_SEL 4
`define SEL_IDX_LOWER 0
`define SEL_IDX_P3 1
`define SEL_IDX_P5 2
`define SEL_IDX_P6 3
`define SEL_REGION_P3 3'h3
`define SEL_REGION_P5 3'h5
`define SEL_REGION_P6 3'h6
`define SEL_REGION_LSB 7
`define SEL_REGION_MSB 9
`define SEL_IO_TOP_LSB 16
`define SEL_IO_BASE_MSB 5
`define SEL_SEL_RST 4'h0
`define SEL_ALAT_RST 2'h0
`endif

//--- logic/select_pkg.sv
// types for the lower-memory and peripheral select block
package select_pkg;
  typedef logic [19:0] addr_t;
  typedef logic [3:0] sel_vec_t;
  // gray path: reset -> capture -> run; test is the side branch
  typedef enum logic [1:0] {
    PH_RESET = 2'h0,
    PH_CAPTURE = 2'h1,
    PH_RUN = 2'h3,
    PH_TEST = 2'h2
  } phase_t;
endpackage

//--- logic/sel_bus_if.sv
// bus-cycle signals shared between the select top and its decoder
`timescale 1ns/10ps
interface sel_bus_if;
  select_pkg::addr_t addr;
  logic io_space;
  logic [8:0] lower_limit_kb;
  logic lower_en;
  logic [9:0] periph_base;
  logic periph_io;
  logic periph_en;
  select_pkg::sel_vec_t hit;
  modport top (output addr, io_space, lower_limit_kb, lower_en, periph_base, periph_io,
    periph_en, input hit);
  modport dec (input addr, io_space, lower_limit_kb, lower_en, periph_base, periph_io,
    periph_en, output hit);
endinterface

//--- logic/region_decoder.sv
// combinational address decode for the lower and peripheral regions
`timescale 1ns/10ps
`include "select_defines.svh"
module region_decoder (
  sel_bus_if.dec bus // address and region programming in, hits out
);
  localparam logic [2:0] REGION_NUM [0:2] = '{`SEL_REGION_P3, `SEL_REGION_P5, `SEL_REGION_P6};
  select_pkg::addr_t lower_end;
  logic base_match;

  assign lower_end = {1'b0, bus.lower_limit_kb, 10'h000};
  // limit is clipped to the bottom half so a large setting cannot spill over
  assign bus.hit[`SEL_IDX_LOWER] = bus.lower_en && !bus.io_space &&
    (bus.addr < `SEL_LOWER_TOP) && (bus.addr < lower_end);

  // i/o space has only 64k, so the top address bits must be zero there
  always_comb begin
    if (bus.periph_io) begin
      base_match = (bus.addr[`SEL_ADDR_W-1:`SEL_IO_TOP_LSB] == 4'h0) &&
        (bus.addr[`SEL_IO_TOP_LSB-1:`SEL_KB_SHIFT] ==
        bus.periph_base[`SEL_IO_BASE_MSB:0]);
    end else begin
      base_match = bus.addr[`SEL_ADDR_W-1:`SEL_KB_SHIFT] == bus.periph_base;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_periph
      assign bus.hit[g+1] = bus.periph_en && (bus.io_space == bus.periph_io) && base_match &&
        (bus.addr[`SEL_REGION_MSB:`SEL_REGION_LSB] == REGION_NUM[g]);
    end
  endgenerate
endmodule

//--- logic/lower_periph_select.sv
// lower-memory and peripheral select pins with latched address option
// Behaviour
// - lower select low on programmed bottom-512k hit
// - lower range set by software programming
// - fifth/sixth selects low on their regions
// - peripheral base programmable, regions relative
// - selects assert with address phase, driven in hold
// - expand bit clear gives latched A1, A2
// - latched address bits hold during bus hold
// - third select low on its region
// - lower pin low at reset release floats pins
`timescale 1ns/10ps
`include "select_defines.svh"
module lower_periph_select (
  input wire logic clk_i, // bus clock, 125 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ale_i, // address phase strobe, one cycle
  input wire logic cycle_end_i, // last cycle of the bus cycle
  input wire logic [19:0] addr_i, // bus address, valid with ale_i
  input wire logic io_space_i, // cycle is an i/o access
  input wire logic hold_i, // bus granted away
  input wire logic [8:0] lower_limit_kb_i, // lower block size in 1k units
  input wire logic lower_enable_i, // lower block programmed
  input wire logic [9:0] periph_base_i, // peripheral block base, 1k units
  input wire logic periph_io_i, // peripheral block lives in i/o space
  input wire logic periph_enable_i, // peripheral block programmed
  input wire logic select_expand_bit_i, // 1: pins 5/6 are selects, 0: A1/A2
  input wire logic lower_mem_select_n_i, // lower select pin level, doubles as test request
  output logic lower_mem_select_n_o, // lower select, active low
  output logic lower_mem_select_n_oe_o, // lower select pin drive enable
  output logic periph_select3_n_o, // third peripheral select, active low
  output logic periph_select5_n_o, // fifth select or latched A1
  output logic periph_select6_n_o, // sixth select or latched A2
  output logic periph_oe_o, // drive enable for the peripheral pins
  output logic test_float_o // test mode: all pins floated
);
  sel_bus_if bus ();
  select_pkg::phase_t phase_r;
  select_pkg::phase_t phase_nxt;
  select_pkg::sel_vec_t sel_r;
  logic [1:0] alat_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic take;
  logic run;

  assign bus.addr = addr_i;
  assign bus.io_space = io_space_i;
  assign bus.lower_limit_kb = lower_limit_kb_i;
  assign bus.lower_en = lower_enable_i;
  assign bus.periph_base = periph_base_i;
  assign bus.periph_io = periph_io_i;
  assign bus.periph_en = periph_enable_i;

  region_decoder u_dec (
    .bus(bus.dec)
  );

  assign run = phase_r == select_pkg::PH_RUN;
  // no new cycle starts while another master owns the bus
  assign take = ale_i && !hold_i && run;

  // the pin comes from outside, so two flops before anything looks at it
  always_ff @(posedge clk_i) begin
    pin_meta_r <= lower_mem_select_n_i;
    pin_sync_r <= pin_meta_r;
  end

  always_comb begin
    case (phase_r)
      select_pkg::PH_RESET: phase_nxt = select_pkg::PH_CAPTURE;
      select_pkg::PH_CAPTURE: begin
        if (!pin_sync_r) begin
          phase_nxt = select_pkg::PH_TEST;
        end else begin
          phase_nxt = select_pkg::PH_RUN;
        end
      end
      select_pkg::PH_RUN: phase_nxt = select_pkg::PH_RUN;
      select_pkg::PH_TEST: phase_nxt = select_pkg::PH_TEST;
      default: phase_nxt = select_pkg::PH_RESET;
    endcase
  end

  // test mode is left only through another reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= select_pkg::PH_RESET;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // a select opens on the address phase and closes at the end of its cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      sel_r <= `SEL_SEL_RST;
    end else if (take) begin
      sel_r <= bus.hit;
    end else if (cycle_end_i) begin
      sel_r <= `SEL_SEL_RST;
    end
  end

  // address bits are frozen while held, never refreshed by the other master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alat_r <= `SEL_ALAT_RST;
    end else if (take) begin
      alat_r <= addr_i[2:1];
    end
  end

  assign lower_mem_select_n_o = !sel_r[`SEL_IDX_LOWER];
  // pin released during reset so the pull-up or a test request can be seen
  assign lower_mem_select_n_oe_o = run;
  assign periph_select3_n_o = !sel_r[`SEL_IDX_P3];
  assign periph_select5_n_o = select_expand_bit_i ? !sel_r[`SEL_IDX_P5] : alat_r[0];
  assign periph_select6_n_o = select_expand_bit_i ? !sel_r[`SEL_IDX_P6] : alat_r[1];
  // hold does not appear here: the pins keep driving while the bus is away
  assign periph_oe_o = run;
  assign test_float_o = phase_r == select_pkg::PH_TEST;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_take;
    ale_i && !hold_i && run;
  endsequence

  sequence s_capture_low;
    phase_r == select_pkg::PH_CAPTURE && !pin_sync_r;
  endsequence

  // decode written out from the pins, not borrowed from the decoder
  sequence s_mem_base;
    periph_enable_i && !periph_io_i && !io_space_i && addr_i[19:10] == periph_base_i;
  endsequence

  sequence s_io_base;
    periph_enable_i && periph_io_i && io_space_i && addr_i[19:16] == 4'h0 &&
      addr_i[15:10] == periph_base_i[5:0];
  endsequence

  AST_LOWER_HIT: assert property (s_take ##0 (!io_space_i && lower_enable_i &&
    addr_i < `SEL_LOWER_TOP && addr_i < {1'b0, lower_limit_kb_i, 10'h000})
    |=> !lower_mem_select_n_o)
    else $error("lower select not asserted on a programmed hit");

  AST_LOWER_TOP: assert property (s_take ##0 (addr_i >= `SEL_LOWER_TOP)
    |=> lower_mem_select_n_o)
    else $error("lower select asserted above the bottom half");

  AST_LOWER_LIMIT: assert property (s_take ##0 (addr_i >= {1'b0, lower_limit_kb_i, 10'h000})
    |=> lower_mem_select_n_o)
    else $error("lower select asserted beyond the programmed size");

  AST_P5_HIT: assert property (s_take ##0 (bus.hit[`SEL_IDX_P5] && select_expand_bit_i)
    ##1 select_expand_bit_i |-> !periph_select5_n_o)
    else $error("fifth select not asserted on its region");

  AST_P6_BASE: assert property (s_take ##0 (!periph_io_i && !io_space_i &&
    addr_i[19:10] != periph_base_i) ##1 select_expand_bit_i |-> periph_select6_n_o)
    else $error("sixth select asserted outside the peripheral base");

  AST_HOLD_DRIVE: assert property (run && hold_i
    |-> periph_oe_o && lower_mem_select_n_oe_o)
    else $error("select pins floated during hold");

  AST_ADDR_BITS: assert property (s_take ##1 !select_expand_bit_i
    |-> periph_select5_n_o == $past(addr_i[1])
    && periph_select6_n_o == $past(addr_i[2]))
    else $error("latched address bits wrong");

  AST_HOLD_KEEP: assert property (hold_i && !select_expand_bit_i ##1 !select_expand_bit_i
    |-> $stable(periph_select5_n_o) && $stable(periph_select6_n_o))
    else $error("latched address bits changed during hold");

  AST_P3_HIT: assert property (s_take ##0 bus.hit[`SEL_IDX_P3] |=> !periph_select3_n_o)
    else $error("third select not asserted on its region");

  AST_TEST_ENTRY: assert property (s_capture_low |=> test_float_o && !periph_oe_o
    && !lower_mem_select_n_oe_o)
    else $error("test request not honoured");

  AST_CYCLE_END: assert property (cycle_end_i && !ale_i |=> lower_mem_select_n_o
    && periph_select3_n_o)
    else $error("select did not release at cycle end");

  AST_P5_REGION: assert property (s_take ##0 s_mem_base ##0 (addr_i[9:7] == `SEL_REGION_P5)
    ##1 select_expand_bit_i |-> !periph_select5_n_o)
    else $error("fifth select missed its region");

  AST_P6_REGION: assert property (s_take ##0 s_mem_base ##0 (addr_i[9:7] == `SEL_REGION_P6)
    ##1 select_expand_bit_i |-> !periph_select6_n_o)
    else $error("sixth select missed its region");

  AST_P3_IO: assert property (s_take ##0 s_io_base ##0 (addr_i[9:7] == `SEL_REGION_P3)
    |=> !periph_select3_n_o)
    else $error("third select missed its i/o region");

  AST_IO_TOP: assert property (s_take ##0 (periph_io_i && addr_i[19:16] != 4'h0)
    |=> periph_select3_n_o)
    else $error("third select asserted above the i/o space");

  AST_SPACE_SPLIT: assert property (s_take ##0 (periph_io_i != io_space_i)
    |=> periph_select3_n_o)
    else $error("third select asserted in the wrong space");

  AST_LOWER_OFF: assert property (s_take ##0 !lower_enable_i
    |=> lower_mem_select_n_o)
    else $error("lower select asserted before programming");

  AST_PERIPH_OFF: assert property (s_take ##0 !periph_enable_i
    |=> periph_select3_n_o)
    else $error("third select asserted before programming");

  AST_IDLE: assert property (!run |-> lower_mem_select_n_o && periph_select3_n_o)
    else $error("select active outside the run phase");

  AST_HOLD_REFUSE: assert property (hold_i && !cycle_end_i |=> $stable(lower_mem_select_n_o)
    && $stable(periph_select3_n_o))
    else $error("select changed while the bus was held");

  AST_TEST_STAYS: assert property (test_float_o |=> test_float_o && !periph_oe_o)
    else $error("test mode left without a reset");

  AST_RUN_ENTRY: assert property (phase_r == select_pkg::PH_CAPTURE && pin_sync_r
    |=> !test_float_o && periph_oe_o && lower_mem_select_n_oe_o)
    else $error("test mode entered without a request");
endmodule

//--- testbench/select_far_side.sv
// far-side model of the shared lower select / test request pin
`timescale 1ns/10ps
module select_far_side (
  input wire logic test_req_i, // pull the pin low to ask for test mode
  input wire logic pin_i, // level the block drives
  input wire logic pin_oe_i, // block drives the pin
  output logic pin_level_o // resolved pad level
);
  // weak pull-up when undriven, so a released pin never shows a stale level
  always_comb begin
    if (pin_oe_i) begin
      pin_level_o = pin_i;
    end else begin
      pin_level_o = ~test_req_i;
    end
  end
endmodule

//--- testbench/lower_periph_select_tb.sv
// self-checking bench for the lower and peripheral select pins
`timescale 1ns/10ps
module lower_periph_select_tb;
  typedef struct {logic [19:0] a; logic io; logic [3:0] sel;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ale_i = 1'b0, cycle_end_i = 1'b0, io_space_i = 1'b0, hold_i = 1'b0;
  logic [19:0] addr_i = 20'h00000;
  logic [8:0] lower_limit_kb_i = 9'h004;
  logic [9:0] periph_base_i = 10'h010;
  logic lower_enable_i = 1'b1, periph_io_i = 1'b0, periph_enable_i = 1'b1;
  logic expand_i = 1'b1, test_req = 1'b0, pin_lvl;
  logic l_n, l_oe, p3, p5, p6, p_oe, tf;
  logic [3:0] sel_w;
  int checks = 0;
  int failures = 0;
  // selects as {lower, third, fifth, sixth}, all active low
  row_t rows[9] = '{'{20'h00100, 1'b0, 4'h7}, '{20'h00FFF, 1'b0, 4'h7},
    '{20'h01000, 1'b0, 4'hF}, '{20'h04180, 1'b0, 4'hB}, '{20'h04280, 1'b0, 4'hD},
    '{20'h04300, 1'b0, 4'hE}, '{20'h04000, 1'b0, 4'hF}, '{20'h04180, 1'b1, 4'hF},
    '{20'h14280, 1'b0, 4'hF}};
  assign sel_w = {l_n, p3, p5, p6};
  lower_periph_select lower_periph_select_inst (.clk_i(clk_i), .rst_i(rst_i), .ale_i(ale_i),
    .cycle_end_i(cycle_end_i), .addr_i(addr_i), .io_space_i(io_space_i), .hold_i(hold_i),
    .lower_limit_kb_i(lower_limit_kb_i), .lower_enable_i(lower_enable_i),
    .periph_base_i(periph_base_i), .periph_io_i(periph_io_i),
    .periph_enable_i(periph_enable_i), .select_expand_bit_i(expand_i),
    .lower_mem_select_n_i(pin_lvl), .lower_mem_select_n_o(l_n),
    .lower_mem_select_n_oe_o(l_oe), .periph_select3_n_o(p3), .periph_select5_n_o(p5),
    .periph_select6_n_o(p6), .periph_oe_o(p_oe), .test_float_o(tf));
  select_far_side select_far_side_inst (.test_req_i(test_req), .pin_i(l_n),
    .pin_oe_i(l_oe), .pin_level_o(pin_lvl));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input logic [19:0] a, input logic io);
    @(posedge clk_i);
    ale_i <= 1'b1;
    addr_i <= a;
    io_space_i <= io;
    @(posedge clk_i);
    ale_i <= 1'b0;
    #1;
  endtask
  task automatic finish();
    @(posedge clk_i);
    cycle_end_i <= 1'b1;
    @(posedge clk_i);
    cycle_end_i <= 1'b0;
    #1;
  endtask
  // pin request must be stable well before release, so it is set with reset
  task automatic do_reset(input logic req, input logic [3:0] exp_run);
    @(posedge clk_i);
    rst_i <= 1'b1;
    test_req <= req;
    repeat (4) @(posedge clk_i);
    #1;
    chk("reset selects", 4'hF, sel_w);
    chk("reset enables", 4'h0, {1'b0, l_oe, p_oe, tf});
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("run enables", exp_run, {1'b0, l_oe, p_oe, tf});
    @(posedge clk_i);
    test_req <= 1'b0;
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b0, 4'h6);
    foreach (rows[k]) begin
      start(rows[k].a, rows[k].io);
      chk("select hit", rows[k].sel, sel_w);
      finish();
      chk("select release", 4'hF, sel_w);
    end
    $display("table test done");
    @(posedge clk_i);
    lower_limit_kb_i <= 9'h008;
    start(20'h01000, 1'b0);
    chk("wider lower", 4'h7, sel_w);
    start(20'h04280, 1'b0);
    chk("back to back", 4'hD, sel_w);
    finish();
    @(posedge clk_i);
    periph_io_i <= 1'b1;
    start(20'h04180, 1'b1);
    chk("io third", 4'hB, sel_w);
    start(20'h04180, 1'b0);
    chk("io memory miss", 4'hF, sel_w);
    start(20'h14180, 1'b1);
    chk("io top bits", 4'hF, sel_w);
    finish();
    @(posedge clk_i);
    periph_io_i <= 1'b0;
    lower_enable_i <= 1'b0;
    periph_enable_i <= 1'b0;
    start(20'h00100, 1'b0);
    chk("lower unprogrammed", 4'hF, sel_w);
    start(20'h04180, 1'b0);
    chk("periph unprogrammed", 4'hF, sel_w);
    finish();
    @(posedge clk_i);
    lower_enable_i <= 1'b1;
    periph_enable_i <= 1'b1;
    $display("programming test done");
    @(posedge clk_i);
    expand_i <= 1'b0;
    start(20'h00104, 1'b0);
    chk("latched bits", 4'h5, sel_w);
    finish();
    chk("latched stand", 4'hD, sel_w);
    @(posedge clk_i);
    hold_i <= 1'b1;
    start(20'h00002, 1'b0);
    chk("hold pins", 4'hD, sel_w);
    chk("hold drive", 4'h3, {2'h0, l_oe, p_oe});
    @(posedge clk_i);
    hold_i <= 1'b0;
    expand_i <= 1'b1;
    $display("hold test done");
    do_reset(1'b1, 4'h1);
    do_reset(1'b0, 4'h6);
    end_of_test();
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule
